// ---- rtl/i2cs_defs.svh ----
// Function
// - Drive data low before releasing clock line
// - Await clock high, then load and count generator
// - Data low at generator expiry means collision
// - Clock low before data rises means collision
// - Port event bit 7, collision bit 6
// - Collision sets flag, port returns idle
// - Abort releases both lines, clears request bits
// - Stop seen, then request cleared, event flagged
`ifndef I2CS_DEFS_SVH
`define I2CS_DEFS_SVH
// Register byte addresses
`define I2CS_OFF_CTRL   8'h00
`define I2CS_OFF_RELOAD 8'h04
`define I2CS_OFF_STAT   8'h08
`define I2CS_OFF_IFLAG  8'h0C
`define I2CS_OFF_ICLR   8'h10
`define I2CS_OFF_IEN    8'h14
`define I2CS_OFF_IPRI   8'h18
// Control bits
`define I2CS_CTRL_STOP  0
`define I2CS_CTRL_START 1
// Status bits
`define I2CS_STAT_SEEN  0
`define I2CS_STAT_BUSY  1
`define I2CS_STAT_LOCK  2
`define I2CS_STAT_SDA   3
`define I2CS_STAT_SCL   4
// Interrupt layout
`define I2CS_IRQ_PORT   7
`define I2CS_IRQ_COLL   6
`define I2CS_IRQ_MASK   8'hC0
// Reset values and widths
`define I2CS_RELOAD_RST 7'h04
`define I2CS_BRG_ZERO   7'h00
`define I2CS_BRG_ONE    7'h01
`define I2CS_RESP_OK    2'h0
`define I2CS_RESP_ERR   2'h2
`endif

// ---- rtl/i2cs_pkg.sv ----
`default_nettype none
package i2cs_pkg;
    // Stop sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_SDA_LOW = 6'h02,
        ST_SCL_REL = 6'h04,
        ST_HOLD    = 6'h08,
        ST_SDA_REL = 6'h10,
        ST_FINISH  = 6'h20
    } i2cs_state_type;

    // Two-wire line group
    typedef struct packed {
        logic scl;
        logic sda;
    } i2cs_pins_type;

    // Baud generator state
    typedef struct packed {
        logic [6:0] cnt;
        logic       run;
    } i2cs_brg_type;

    // Whole controller state
    typedef struct packed {
        i2cs_state_type state;
        logic           stop_req;
        logic           lock;
        logic           seen;
        logic [6:0]     reload;
        logic [7:0]     iflag;
        logic [7:0]     ien;
        logic [7:0]     ipri;
        logic           irq;
        i2cs_pins_type  pin_o;
        i2cs_pins_type  pin_oe_n;
        logic           aw_got;
        logic [7:0]     awaddr;
        logic           w_got;
        logic [7:0]     wdata;
        logic           wstrb0;
        logic           awready;
        logic           wready;
        logic           bvalid;
        logic [1:0]     bresp;
        logic           arready;
        logic           rvalid;
        logic [31:0]    rdata;
        logic [1:0]     rresp;
    } i2cs_core_type;
endpackage : i2cs_pkg
`default_nettype wire

// ---- rtl/i2cs_brg.sv ----
`default_nettype none
`include "i2cs_defs.svh"
module i2cs_brg (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       load,
    input  wire logic [6:0] reload,
    output logic            done,
    output logic            busy
);
    import i2cs_pkg::*;

    i2cs_brg_type brg_ff;  // Counter state
    i2cs_brg_type nxt_brg; // Next counter state

    // Count down from the reload value to zero
    always_comb begin
        nxt_brg = brg_ff;
        if (load) begin
            nxt_brg.cnt = reload;
            nxt_brg.run = 1'b1;
        end else if (brg_ff.run) begin
            if (brg_ff.cnt == `I2CS_BRG_ZERO) begin
                nxt_brg.run = 1'b0;
            end else begin
                nxt_brg.cnt = brg_ff.cnt - `I2CS_BRG_ONE;
            end
        end
    end

    // Expiry pulse lasts one cycle
    assign done = brg_ff.run && (brg_ff.cnt == `I2CS_BRG_ZERO);
    assign busy = brg_ff.run;

    // Register the state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            brg_ff <= '0;
        end else begin
            brg_ff <= nxt_brg;
        end
    end
endmodule : i2cs_brg
`default_nettype wire

// ---- rtl/i2cs_stop_ctl.sv ----
`default_nettype none
`include "i2cs_defs.svh"
module i2cs_stop_ctl (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire i2cs_pkg::i2cs_pins_type pin_i,
    output i2cs_pkg::i2cs_pins_type      pin_o,
    output i2cs_pkg::i2cs_pins_type      pin_oe_n,
    output logic                  irq
);
    import i2cs_pkg::*;

    i2cs_core_type core_ff;  // All state
    i2cs_core_type nxt_core; // Next state
    logic          brg_load; // Restart baud generator
    logic          brg_done; // Generator expired
    logic          brg_busy; // Generator counting

    // Reset image: lines released, idle
    localparam i2cs_core_type CORE_RST = '{
        state:    ST_IDLE,
        reload:   `I2CS_RELOAD_RST,
        pin_oe_n: '{scl: 1'b1, sda: 1'b1},
        default:  '0
    };

    // Address is one of ours
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `I2CS_OFF_CTRL)  || (a == `I2CS_OFF_RELOAD) ||
                    (a == `I2CS_OFF_STAT)  || (a == `I2CS_OFF_IFLAG)  ||
                    (a == `I2CS_OFF_ICLR)  || (a == `I2CS_OFF_IEN)    ||
                    (a == `I2CS_OFF_IPRI);
    endfunction : is_mapped

    // Read value of a register
    function automatic logic [31:0] rd_value(input logic [7:0]    a,
                                             input i2cs_core_type c,
                                             input i2cs_pins_type p);
        rd_value = 32'h0;
        case (a)
            `I2CS_OFF_CTRL: begin
                rd_value[`I2CS_CTRL_STOP] = c.stop_req;
            end
            `I2CS_OFF_RELOAD: begin
                rd_value[6:0] = c.reload;
            end
            `I2CS_OFF_STAT: begin
                rd_value[`I2CS_STAT_SEEN] = c.seen;
                rd_value[`I2CS_STAT_BUSY] = (c.state != ST_IDLE);
                rd_value[`I2CS_STAT_LOCK] = c.lock;
                rd_value[`I2CS_STAT_SDA]  = p.sda;
                rd_value[`I2CS_STAT_SCL]  = p.scl;
            end
            `I2CS_OFF_IFLAG: begin
                rd_value[7:0] = c.iflag;
            end
            `I2CS_OFF_IEN: begin
                rd_value[7:0] = c.ien;
            end
            `I2CS_OFF_IPRI: begin
                rd_value[7:0] = c.ipri;
            end
            // Clear register and holes read zero
            default: begin
                rd_value = 32'h0;
            end
        endcase
    endfunction : rd_value

    // Generator timing the hold, data-release and finish phases
    i2cs_brg u_brg (
        .aclk    (aclk),
        .aresetn (aresetn),
        .load    (brg_load),
        .reload  (core_ff.reload),
        .done    (brg_done),
        .busy    (brg_busy)
    );

    // Next-state logic: bus slave, registers, sequencer
    always_comb begin
        logic          wr_fire; // Both write halves held
        logic          coll;    // Collision this cycle
        logic [7:0]    clr;     // Software clear mask
        nxt_core = core_ff;
        brg_load = 1'b0;
        coll     = 1'b0;
        clr      = 8'h00;
        wr_fire  = 1'b0;

        // Write address channel
        if (s_axi_awvalid && core_ff.awready) begin
            nxt_core.aw_got = 1'b1;
            nxt_core.awaddr = s_axi_awaddr;
        end
        // Write data channel, only the low lane matters
        if (s_axi_wvalid && core_ff.wready) begin
            nxt_core.w_got  = 1'b1;
            nxt_core.wdata  = s_axi_wdata[7:0];
            nxt_core.wstrb0 = s_axi_wstrb[0];
        end
        // Response retires
        if (core_ff.bvalid && s_axi_bready) begin
            nxt_core.bvalid = 1'b0;
        end

        // Perform a write once both halves are in
        if (core_ff.aw_got && core_ff.w_got && !core_ff.bvalid) begin
            wr_fire         = core_ff.wstrb0;
            nxt_core.aw_got = 1'b0;
            nxt_core.w_got  = 1'b0;
            nxt_core.bvalid = 1'b1;
            nxt_core.bresp  = is_mapped(core_ff.awaddr) ?
                              `I2CS_RESP_OK : `I2CS_RESP_ERR;
        end
        if (wr_fire) begin
            case (core_ff.awaddr)
                `I2CS_OFF_CTRL: begin
                    // Start request lifts the post-collision lock
                    if (core_ff.wdata[`I2CS_CTRL_START]) begin
                        nxt_core.lock = 1'b0;
                    end
                    // Stop taken only when idle and unlocked
                    if (core_ff.wdata[`I2CS_CTRL_STOP] &&
                        core_ff.state == ST_IDLE && !core_ff.lock) begin
                        nxt_core.stop_req = 1'b1;
                    end
                end
                `I2CS_OFF_RELOAD: begin
                    nxt_core.reload = core_ff.wdata[6:0];
                end
                `I2CS_OFF_ICLR: begin
                    clr = core_ff.wdata & `I2CS_IRQ_MASK;
                end
                `I2CS_OFF_IEN: begin
                    nxt_core.ien = core_ff.wdata & `I2CS_IRQ_MASK;
                end
                `I2CS_OFF_IPRI: begin
                    nxt_core.ipri = core_ff.wdata & `I2CS_IRQ_MASK;
                end
                // Read-only or unmapped: no effect
                default: begin
                end
            endcase
        end
        // Clear first so a same-cycle event wins
        nxt_core.iflag = core_ff.iflag & ~clr;

        // Read channel: one read in flight
        if (core_ff.rvalid && s_axi_rready) begin
            nxt_core.rvalid = 1'b0;
        end
        if (s_axi_arvalid && core_ff.arready) begin
            nxt_core.rvalid = 1'b1;
            nxt_core.rdata  = rd_value(s_axi_araddr, core_ff, pin_i);
            nxt_core.rresp  = is_mapped(s_axi_araddr) ?
                              `I2CS_RESP_OK : `I2CS_RESP_ERR;
        end

        // Stop sequencer
        unique case (core_ff.state)
            ST_IDLE: begin
                if (core_ff.stop_req) begin
                    // Pull data low, pull clock low too
                    nxt_core.seen         = 1'b0;
                    nxt_core.pin_oe_n.sda = 1'b0;
                    nxt_core.pin_oe_n.scl = 1'b0;
                    nxt_core.state        = ST_SDA_LOW;
                end
            end
            ST_SDA_LOW: begin
                // Clock freed only once data is seen low
                if (!pin_i.sda) begin
                    nxt_core.pin_oe_n.scl = 1'b1;
                    nxt_core.state        = ST_SCL_REL;
                end
            end
            ST_SCL_REL: begin
                // Stretching: wait as long as the clock is held
                if (pin_i.scl) begin
                    brg_load       = 1'b1;
                    nxt_core.state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!pin_i.scl) begin
                    coll = 1'b1;
                end else if (brg_done) begin
                    // Let data float and time one period
                    nxt_core.pin_oe_n.sda = 1'b1;
                    brg_load              = 1'b1;
                    nxt_core.state        = ST_SDA_REL;
                end
            end
            ST_SDA_REL: begin
                if (!pin_i.scl && !pin_i.sda) begin
                    coll = 1'b1;
                end else if (brg_done) begin
                    if (!pin_i.sda) begin
                        coll = 1'b1;
                    end else if (pin_i.scl) begin
                        nxt_core.seen  = 1'b1;
                        brg_load       = 1'b1;
                        nxt_core.state = ST_FINISH;
                    end else begin
                        coll = 1'b1;
                    end
                end
            end
            ST_FINISH: begin
                // One more period, then report completion
                if (brg_done) begin
                    nxt_core.stop_req                = 1'b0;
                    nxt_core.iflag[`I2CS_IRQ_PORT]   = 1'b1;
                    nxt_core.state                   = ST_IDLE;
                end
            end
            default: begin
                // Illegal code: fall back to idle, lines released
                nxt_core.state        = ST_IDLE;
                nxt_core.pin_oe_n.sda = 1'b1;
                nxt_core.pin_oe_n.scl = 1'b1;
            end
        endcase

        // Collision abort wins over any step above
        if (coll) begin
            nxt_core.iflag[`I2CS_IRQ_COLL] = 1'b1;
            nxt_core.state                 = ST_IDLE;
            nxt_core.pin_oe_n.sda          = 1'b1;
            nxt_core.pin_oe_n.scl          = 1'b1;
            nxt_core.stop_req              = 1'b0;
            nxt_core.lock                  = 1'b1;
        end

        // Lines are open drain: value is always low
        nxt_core.pin_o   = '0;
        // Ready flags computed ahead so outputs are flops
        nxt_core.awready = !nxt_core.aw_got && !nxt_core.bvalid;
        nxt_core.wready  = !nxt_core.w_got && !nxt_core.bvalid;
        nxt_core.arready = !nxt_core.rvalid;
        // Level interrupt from enabled sticky flags
        nxt_core.irq     = |(nxt_core.iflag & nxt_core.ien);
    end

    // Register the whole state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_ff <= CORE_RST;
        end else begin
            core_ff <= nxt_core;
        end
    end

    // Outputs straight from flops
    assign s_axi_awready = core_ff.awready;
    assign s_axi_wready  = core_ff.wready;
    assign s_axi_bvalid  = core_ff.bvalid;
    assign s_axi_bresp   = core_ff.bresp;
    assign s_axi_arready = core_ff.arready;
    assign s_axi_rvalid  = core_ff.rvalid;
    assign s_axi_rdata   = core_ff.rdata;
    assign s_axi_rresp   = core_ff.rresp;
    assign pin_o         = core_ff.pin_o;
    assign pin_oe_n      = core_ff.pin_oe_n;
    assign irq           = core_ff.irq;

    // Checks on the sequencer
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Completion of a good Stop
    sequence s_stop_seen;
        $rose(core_ff.seen) && core_ff.stop_req;
    endsequence
    sequence s_stop_done;
        !core_ff.stop_req && core_ff.iflag[`I2CS_IRQ_PORT];
    endsequence

    // Collision abort state
    sequence s_aborted;
        core_ff.state == ST_IDLE && core_ff.pin_oe_n.sda &&
        core_ff.pin_oe_n.scl && !core_ff.stop_req;
    endsequence

    sda_before_scl_a: assert property (
        $rose(core_ff.state == ST_SCL_REL) |-> !$past(pin_i.sda) &&
        !$past(core_ff.pin_oe_n.sda))
        else $error("clock released before data seen low");

    brg_start_a: assert property (
        core_ff.state == ST_SCL_REL && pin_i.scl |=>
        core_ff.state == ST_HOLD && brg_busy)
        else $error("generator not loaded after clock high");

    sda_coll_a: assert property (
        core_ff.state == ST_SDA_REL && brg_done && !pin_i.sda |=>
        core_ff.iflag[`I2CS_IRQ_COLL] ##0 s_aborted)
        else $error("data low at expiry not flagged");

    scl_coll_a: assert property (
        core_ff.state == ST_HOLD && !pin_i.scl |=>
        core_ff.iflag[`I2CS_IRQ_COLL] && core_ff.lock)
        else $error("clock low during stop not flagged");

    flag_layout_a: assert property (
        (core_ff.iflag & ~`I2CS_IRQ_MASK) == 8'h00 &&
        (core_ff.ien & ~`I2CS_IRQ_MASK) == 8'h00)
        else $error("flag or enable outside bits 7 and 6");

    coll_idle_a: assert property (
        $rose(core_ff.iflag[`I2CS_IRQ_COLL]) |-> core_ff.state == ST_IDLE)
        else $error("collision flag without return to idle");

    abort_release_a: assert property (
        $rose(core_ff.lock) |-> s_aborted)
        else $error("abort left a line driven or request set");

    stop_finish_a: assert property (
        s_stop_seen |-> ##[1:130] s_stop_done)
        else $error("stop not completed one period after seen");

    lock_idle_a: assert property (
        core_ff.lock |-> core_ff.state == ST_IDLE &&
        core_ff.pin_oe_n.sda && core_ff.pin_oe_n.scl)
        else $error("line driven while locked after collision");

    irq_level_a: assert property (
        irq == $past(|(nxt_core.iflag & nxt_core.ien)))
        else $error("interrupt does not follow enabled flags");
endmodule : i2cs_stop_ctl
`default_nettype wire

// ---- tb/i2cs_bus_model.sv ----
`default_nettype none
// Other parties on the shared two-wire bus: pull-ups, a clock-stretching
// slave and a rival master that can be told to drive either line low
module i2cs_bus_model (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    hold_sda,
    input  wire logic                    grab_scl,
    input  wire i2cs_pkg::i2cs_pins_type dut_oe_n,
    output i2cs_pkg::i2cs_pins_type      line
);
    timeunit 1ns;
    timeprecision 100ps;
    import i2cs_pkg::*;

    logic [1:0] stretch_ff;  // Remaining stretch cycles
    logic       pull_scl_ff; // Rival master holds clock low

    // Stretch the clock three cycles after every low phase, so the
    // controller must wait for the real high level, not its own release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stretch_ff  <= 2'h0;
            pull_scl_ff <= 1'b0;
        end else begin
            if (!dut_oe_n.scl) begin
                stretch_ff <= 2'h3;
            end else if (stretch_ff != 2'h0) begin
                stretch_ff <= stretch_ff - 2'h1;
            end
            // Rival drags the clock down once it has seen it high
            if (!grab_scl) begin
                pull_scl_ff <= 1'b0;
            end else if (line.scl) begin
                pull_scl_ff <= 1'b1;
            end
        end
    end

    // Wired-AND with pull-ups: released lines read high
    // One driver for the whole line group
    assign line = '{scl: dut_oe_n.scl & (stretch_ff == 2'h0) & ~pull_scl_ff,
                    sda: dut_oe_n.sda & ~hold_sda};
endmodule : i2cs_bus_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`default_nettype none
`include "i2cs_defs.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; $display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import i2cs_pkg::*;

    logic          aclk;        // Bus clock, 40 MHz
    logic          aresetn;     // Synchronous reset
    logic [7:0]    awaddr;      // Write channel
    logic          awvalid;
    logic          awready;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          wvalid;
    logic          wready;
    logic [1:0]    bresp;
    logic          bvalid;
    logic          bready;
    logic [7:0]    araddr;      // Read channel
    logic          arvalid;
    logic          arready;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic          rvalid;
    logic          rready;
    i2cs_pins_type pins;        // Resolved line levels
    i2cs_pins_type pin_o;
    i2cs_pins_type pin_oe_n;
    i2cs_pins_type last_oe;     // Enables one edge earlier
    logic          irq;
    logic          hold_sda;    // Rival holds data low
    logic          grab_scl;    // Rival pulls clock low
    logic          timing_on;   // Check generator wait
    logic [6:0]    chk_r;       // Reload in use
    int            hi_cnt;      // Clock-high cycles before data release
    int            bad_count;
    int            n_checks;
    logic [33:0]   rq[$];       // Expected {rresp, rdata}
    logic [1:0]    bq[$];       // Expected bresp
    logic [7:0]    pri;

    i2cs_stop_ctl i2cs_stop_ctl_i (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_i(pins),
        .pin_o(pin_o), .pin_oe_n(pin_oe_n), .irq(irq)
    );

    i2cs_bus_model i2cs_bus_model_i (
        .aclk(aclk), .aresetn(aresetn), .hold_sda(hold_sda),
        .grab_scl(grab_scl), .dut_oe_n(pin_oe_n), .line(pins)
    );

    // Free-running clock
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // Verdict and end of run
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    // A wait that ran out
    task automatic timeout;
        bad_count++;
        $display("wrong value at %0t: wait ran out", $time);
        finish_test();
    endtask : timeout

    // Register write; response checked by the monitor
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        int i;
        @(posedge aclk);
        bq.push_back(r);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1 && !awvalid && !wvalid) break;
        end
        if (i == 100) timeout();
        bready <= 1'b0;
    endtask : wr

    // Register read; data checked by the monitor
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        int i;
        @(posedge aclk);
        rq.push_back({r, 24'h0, d});
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1 && !arvalid) break;
        end
        if (i == 100) timeout();
        rready <= 1'b0;
    endtask : rd

    // Bounded wait for a given {irq, enables} pattern
    task automatic wait_for(input logic [2:0] want);
        int i;
        for (i = 0; i < 500; i++) begin
            @(posedge aclk);
            if ({irq, pin_oe_n} === want) break;
        end
        if (i == 500) timeout();
    endtask : wait_for

    // Result monitor: oldest note against each answer
    always @(posedge aclk) begin
        if (rvalid && rready && rq.size() > 0) `CHK({rresp, rdata}, rq.pop_front())
        if (bvalid && bready && bq.size() > 0) `CHK(bresp, bq.pop_front())
    end

    // Line sequencing watcher
    always @(posedge aclk) begin
        last_oe <= pin_oe_n;
        if (pin_oe_n.scl && !last_oe.scl && !pin_oe_n.sda) `CHK(last_oe.sda, 1'b0)
        if (pin_oe_n == 2'b00) hi_cnt <= 0;
        else if (pin_oe_n == 2'b10 && pins.scl) hi_cnt <= hi_cnt + 1;
        if (timing_on && pin_oe_n.sda && !last_oe.sda && last_oe.scl)
            `CHK(hi_cnt >= int'(chk_r) + 1, 1'b1)
    end

    // Main sequence
    initial begin
        {aresetn, awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready, hold_sda, grab_scl, timing_on} = '0;
        wstrb     = 4'hF;
        chk_r     = 7'h04;
        hi_cnt    = 0;
        last_oe   = 2'b11;
        bad_count = 0;
        n_checks  = 0;
        void'($urandom(32'hD97D));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values of reload, flags, enables and status
        rd(`I2CS_OFF_RELOAD, 8'h04, `I2CS_RESP_OK);
        rd(`I2CS_OFF_IFLAG, 8'h00, `I2CS_RESP_OK);
        rd(`I2CS_OFF_IEN, 8'h00, `I2CS_RESP_OK);
        rd(`I2CS_OFF_STAT, 8'h18, `I2CS_RESP_OK);
        // Low byte lane off: write answered but ignored
        wstrb <= 4'h0;
        wr(`I2CS_OFF_RELOAD, 8'h11, `I2CS_RESP_OK);
        wstrb <= 4'hF;
        rd(`I2CS_OFF_RELOAD, 8'h04, `I2CS_RESP_OK);
        rd(8'h1C, 8'h00, `I2CS_RESP_ERR);
        wr(8'h1C, 8'hFF, `I2CS_RESP_ERR);
        pri = 8'($urandom);
        wr(`I2CS_OFF_IPRI, pri, `I2CS_RESP_OK);
        rd(`I2CS_OFF_IPRI, pri & 8'hC0, `I2CS_RESP_OK);
        wr(`I2CS_OFF_IEN, 8'hC0, `I2CS_RESP_OK);
        // Two clean Stops with random reload values
        repeat (2) begin
            chk_r = 7'(1 + $urandom % 6);
            wr(`I2CS_OFF_RELOAD, {1'b0, chk_r}, `I2CS_RESP_OK);
            timing_on <= 1'b1;
            wr(`I2CS_OFF_CTRL, 8'h01, `I2CS_RESP_OK);
            wait_for(3'b111);
            timing_on <= 1'b0;
            rd(`I2CS_OFF_IFLAG, 8'h80, `I2CS_RESP_OK);
            rd(`I2CS_OFF_STAT, 8'h19, `I2CS_RESP_OK);
            rd(`I2CS_OFF_CTRL, 8'h00, `I2CS_RESP_OK);
            wr(`I2CS_OFF_ICLR, 8'hC0, `I2CS_RESP_OK);
            rd(`I2CS_OFF_IFLAG, 8'h00, `I2CS_RESP_OK);
            `CHK(irq, 1'b0)
        end
        // Rival keeps data low past the generator expiry
        hold_sda <= 1'b1;
        wr(`I2CS_OFF_CTRL, 8'h01, `I2CS_RESP_OK);
        wait_for(3'b111);
        hold_sda <= 1'b0;
        rd(`I2CS_OFF_IFLAG, 8'h40, `I2CS_RESP_OK);
        rd(`I2CS_OFF_CTRL, 8'h00, `I2CS_RESP_OK);
        // Locked: a new Stop request must not touch the lines
        wr(`I2CS_OFF_CTRL, 8'h01, `I2CS_RESP_OK);
        repeat (3) @(posedge aclk);
        `CHK(pin_oe_n, 2'b11)
        rd(`I2CS_OFF_CTRL, 8'h00, `I2CS_RESP_OK);
        wr(`I2CS_OFF_CTRL, 8'h02, `I2CS_RESP_OK);
        wr(`I2CS_OFF_ICLR, 8'hC0, `I2CS_RESP_OK);
        // Rival pulls the clock low before data release, irq masked
        wr(`I2CS_OFF_IEN, 8'h00, `I2CS_RESP_OK);
        wr(`I2CS_OFF_CTRL, 8'h01, `I2CS_RESP_OK);
        wait_for(3'b010);
        // Arm the rival only once the clock is released, else it
        // would hold the idle clock low and the Stop would never load
        grab_scl <= 1'b1;
        wait_for(3'b011);
        grab_scl <= 1'b0;
        `CHK(irq, 1'b0)
        `CHK(pin_o, 2'b00)
        rd(`I2CS_OFF_IFLAG, 8'h40, `I2CS_RESP_OK);
        wr(`I2CS_OFF_IEN, 8'h40, `I2CS_RESP_OK);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b1)
        wr(`I2CS_OFF_ICLR, 8'h40, `I2CS_RESP_OK);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0)
        wr(`I2CS_OFF_CTRL, 8'h02, `I2CS_RESP_OK);
        rd(`I2CS_OFF_STAT, 8'h18, `I2CS_RESP_OK);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
